// >>> verilog/btd_pkg.sv
// Purpose: shared constants of the burst-of-two DDR SRAM port and its controller
// Assumes: core clock of 20 MHz
// Notes: memory depth is kept small because storage is flip-flops
`default_nettype none
package btd_pkg;
    localparam int WORD_W = 18;
    localparam int LANE_W = 9;
    localparam int LANES = WORD_W / LANE_W;
    localparam int ADDR_W_DEF = 4;
    localparam int CLK_NS = 50;
    localparam int K_PERIOD_NS = 400;
    localparam int HALF_DIV_DEF = K_PERIOD_NS / (2 * CLK_NS);
    localparam int LOCK_US = 20;
    localparam int LOCK_CYC = (LOCK_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int PLL_STOP_NS = 30;
    localparam int STOP_CYC = (PLL_STOP_NS + CLK_NS - 1) / CLK_NS;
    localparam int KGAP_CYC_DEF = HALF_DIV_DEF + STOP_CYC;
    localparam int IMP_CAL_K = 1024;
    localparam int TURN_IDLE_DEF = 2;
endpackage
`default_nettype wire

// >>> verilog/btd_link_if.sv
// Purpose: pins between the memory controller and the SRAM port
// Assumes: the shared data bus floats high when nobody drives it
// Notes: output enables are active low
`default_nettype none
interface btd_link_if #(
    parameter int AW = btd_pkg::ADDR_W_DEF
);
    logic kClk;
    logic kClkN;
    logic loadN;
    logic readSel;
    logic loopBypassN;
    logic [btd_pkg::LANES-1:0] byteMaskN;
    logic [AW-1:0] addr;
    logic [btd_pkg::WORD_W-1:0] dqHost;
    logic dqHostOeN;
    logic [btd_pkg::WORD_W-1:0] dqDev;
    logic dqDevOeN;
    logic [btd_pkg::WORD_W-1:0] dq;
    logic echoClk;
    logic echoClkN;
    logic readValid;
    // wire level of the shared data bus
    assign dq = !dqDevOeN ? dqDev : (!dqHostOeN ? dqHost : '1);
    modport ctrl (
        output kClk, kClkN, loadN, readSel, loopBypassN, byteMaskN, addr, dqHost, dqHostOeN,
        input dq, echoClk, echoClkN, readValid
    );
    modport sram (
        input kClk, kClkN, loadN, readSel, loopBypassN, byteMaskN, addr, dq,
        output dqDev, dqDevOeN, echoClk, echoClkN, readValid
    );
endinterface
`default_nettype wire

// >>> verilog/btd_sync.sv
// Purpose: two-flop synchroniser for a bundle of pins
// Assumes: each bit is an independent level
// Notes: only the second stage may be read
`default_nettype none
module btd_sync #(
    parameter int W = 1
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] stage1;
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            stage1 <= '0;
            dout <= '0;
        end else begin
            stage1 <= din;
            dout <= stage1;
        end
    end
endmodule
`default_nettype wire

// >>> verilog/btd_sram_end.sv
// Purpose: SRAM side of a two-word burst DDR port, flip-flop storage
// Assumes: link clocks and pins sampled by core_clk after two flops
// Notes: the newest write always stays posted until the next write
// Summary of operation
// - pll on: first read word two K later
// - pll off: first read word one K later
// - accesses start and controls sample on K rise
// - direction high, load low starts a read
// - word0 on K rise, word1 on Kn rise
// - two arrays, each access moves two words
// - reads every K, never aborted
// - finish reads, then float bus after K
// - direction low, load low starts a write
// - word0 next K, word1 next Kn, stored together
// - back-to-back writes pipeline every K rise
// - after pending write data, inputs ignored
// - low byte mask stores lane, high keeps
// - controller idles two cycles read to write
// - write after read held posted in registers
// - read of posted address returns register data
// - controller gives each bank own load; here one loadN drives the single bank
// - recalibrate impedance every 1024 K cycles
// - free running echo clocks follow K, Kn
// - read valid rises half cycle before data
// - pll locks after stable clock, stop resets
`default_nettype none
module btd_sram_end #(
    parameter int AW = btd_pkg::ADDR_W_DEF,
    parameter int KGAP = btd_pkg::KGAP_CYC_DEF
) (
    input wire logic core_clk,
    input wire logic arst_n,
    btd_link_if.sram link,
    output logic pllLocked,
    output logic impCalPulse
);
    localparam int WW = btd_pkg::WORD_W;
    localparam int LW = btd_pkg::LANE_W;
    localparam int NL = btd_pkg::LANES;
    localparam int DEPTH = 1 << AW;
    localparam int SW = 5 + NL + AW + WW;
    localparam int CW = $clog2(btd_pkg::IMP_CAL_K);
    localparam int KW = $clog2(btd_pkg::LOCK_CYC + 1);
    localparam int GW = $clog2(KGAP + 2);

    generate
        if (AW < 1 || KGAP < 2 || WW % LW != 0) begin : gBadParam
            $error("btd_sram_end: unsupported parameters");
        end
    endgenerate

    logic [SW-1:0] syncOut;
    logic kS, knS, loadNS, readSelS, pllOnS;
    logic [NL-1:0] maskNS, maskPrev;
    logic [AW-1:0] addrS;
    logic [WW-1:0] dqS;

    btd_sync #(.W(SW)) uSync (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .din({link.kClk, link.kClkN, link.loadN, link.readSel, link.loopBypassN,
              link.byteMaskN, link.addr, link.dq}),
        .dout(syncOut)
    );
    assign {kS, knS, loadNS, readSelS, pllOnS, maskNS, addrS, dqS} = syncOut;

    logic kPrev, knPrev, next_kPrev, next_knPrev;
    logic cmdWr, next_cmdWr, phase1, next_phase1;
    logic [AW-1:0] cmdWrAddr, next_cmdWrAddr;
    logic postValid, next_postValid;
    logic [AW-1:0] postAddr, next_postAddr;
    logic [1:0][WW-1:0] postData, next_postData;
    logic [1:0][NL-1:0] postEn, next_postEn;
    logic [1:0][WW-1:0] mem [DEPTH];
    logic [1:0][WW-1:0] next_mem [DEPTH];
    logic rd1V, rd2V, next_rd1V, next_rd2V;
    logic [AW-1:0] rd1A, rd2A, outA, next_rd1A, next_rd2A, next_outA;
    logic outBusy, next_outBusy;
    logic [WW-1:0] next_dqDev, dqPrev;
    logic next_dqDevOeN, next_readValid, next_echoClk, next_echoClkN;
    logic [CW-1:0] calCnt, next_calCnt;
    logic next_impCalPulse;
    logic [KW-1:0] lockCnt, next_lockCnt;
    logic [GW-1:0] gapCnt, next_gapCnt;
    logic next_pllLocked;
    logic kRise, knRise, dueV;
    logic [AW-1:0] dueA;

    // array word merged with the posted write lane by lane
    function automatic logic [WW-1:0] fetch(input logic [AW-1:0] a, input int idx);
        logic [WW-1:0] w;
        w = mem[a][idx];
        if (postValid && postAddr == a) begin
            for (int l = 0; l < NL; l++) begin
                if (postEn[idx][l]) begin
                    w[l*LW +: LW] = postData[idx][l*LW +: LW];
                end
            end
        end
        return w;
    endfunction

    assign kRise = kS && !kPrev;
    assign knRise = knS && !knPrev;
    assign dueV = pllOnS ? rd2V : rd1V;
    assign dueA = pllOnS ? rd2A : rd1A;

    always_comb begin
        next_kPrev = kS;
        next_knPrev = knS;
        next_cmdWr = cmdWr;
        next_cmdWrAddr = cmdWrAddr;
        next_phase1 = phase1;
        next_postValid = postValid;
        next_postAddr = postAddr;
        next_postData = postData;
        next_postEn = postEn;
        next_mem = mem;
        next_rd1V = rd1V;
        next_rd1A = rd1A;
        next_rd2V = rd2V;
        next_rd2A = rd2A;
        next_outA = outA;
        next_outBusy = outBusy;
        next_dqDev = link.dqDev;
        next_dqDevOeN = link.dqDevOeN;
        next_readValid = link.readValid;
        next_echoClk = kS;
        next_echoClkN = knS;
        next_calCnt = calCnt;
        next_impCalPulse = 1'b0;
        if (kRise) begin
            if (cmdWr) begin
                // the previous write is complete: commit it, post the new one
                if (postValid) begin
                    for (int w = 0; w < 2; w++) begin
                        for (int l = 0; l < NL; l++) begin
                            if (postEn[w][l]) begin
                                next_mem[postAddr][w][l*LW +: LW] = postData[w][l*LW +: LW];
                            end
                        end
                    end
                end
                next_postValid = 1'b1;
                next_postAddr = cmdWrAddr;
                next_postData[0] = dqPrev;
                next_postEn[0] = ~maskPrev;
                next_postEn[1] = '0;
                next_phase1 = 1'b1;
            end
            next_cmdWr = !loadNS && !readSelS;
            next_cmdWrAddr = addrS;
            next_rd1V = !loadNS && readSelS;
            next_rd1A = addrS;
            next_rd2V = rd1V;
            next_rd2A = rd1A;
            if (dueV) begin
                next_dqDev = fetch(dueA, 0);
                next_dqDevOeN = 1'b0;
                next_outA = dueA;
                next_outBusy = 1'b1;
            end else begin
                next_dqDevOeN = 1'b1;
                next_outBusy = 1'b0;
            end
            next_calCnt = calCnt + 1'b1;
            next_impCalPulse = &calCnt;
        end
        if (knRise) begin
            if (phase1) begin
                next_postData[1] = dqPrev;
                next_postEn[1] = ~maskPrev;
                next_phase1 = 1'b0;
            end
            if (outBusy) begin
                next_dqDev = fetch(outA, 1);
                next_outBusy = 1'b0;
            end
            next_readValid = dueV;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            kPrev <= 1'b0;
            knPrev <= 1'b0;
            cmdWr <= 1'b0;
            cmdWrAddr <= '0;
            phase1 <= 1'b0;
            postValid <= 1'b0;
            postAddr <= '0;
            postData <= '0;
            postEn <= '0;
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= '0;
            end
            rd1V <= 1'b0;
            rd1A <= '0;
            rd2V <= 1'b0;
            rd2A <= '0;
            outA <= '0;
            outBusy <= 1'b0;
            link.dqDev <= '0;
            link.dqDevOeN <= 1'b1;
            link.readValid <= 1'b0;
            link.echoClk <= 1'b0;
            link.echoClkN <= 1'b0;
            calCnt <= '0;
            impCalPulse <= 1'b0;
            dqPrev <= '0;
            maskPrev <= '1;
        end else begin
            kPrev <= next_kPrev;
            knPrev <= next_knPrev;
            cmdWr <= next_cmdWr;
            cmdWrAddr <= next_cmdWrAddr;
            phase1 <= next_phase1;
            postValid <= next_postValid;
            postAddr <= next_postAddr;
            postData <= next_postData;
            postEn <= next_postEn;
            mem <= next_mem;
            rd1V <= next_rd1V;
            rd1A <= next_rd1A;
            rd2V <= next_rd2V;
            rd2A <= next_rd2A;
            outA <= next_outA;
            outBusy <= next_outBusy;
            link.dqDev <= next_dqDev;
            link.dqDevOeN <= next_dqDevOeN;
            link.readValid <= next_readValid;
            link.echoClk <= next_echoClk;
            link.echoClkN <= next_echoClkN;
            calCnt <= next_calCnt;
            impCalPulse <= next_impCalPulse;
            dqPrev <= dqS; // data as it stood before the K edge
            maskPrev <= maskNS;
        end
    end

    // lock timer restarts whenever K holds one level too long
    always_comb begin
        next_gapCnt = gapCnt;
        next_lockCnt = lockCnt;
        next_pllLocked = pllLocked;
        if (kS != kPrev) begin
            next_gapCnt = '0;
        end else if (gapCnt <= GW'(KGAP)) begin
            next_gapCnt = gapCnt + 1'b1;
        end
        if (!pllOnS || gapCnt > GW'(KGAP)) begin
            next_lockCnt = '0;
            next_pllLocked = 1'b0;
        end else if (lockCnt < KW'(btd_pkg::LOCK_CYC)) begin
            next_lockCnt = lockCnt + 1'b1;
        end else begin
            next_pllLocked = 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            gapCnt <= '0;
            lockCnt <= '0;
            pllLocked <= 1'b0;
        end else begin
            gapCnt <= next_gapCnt;
            lockCnt <= next_lockCnt;
            pllLocked <= next_pllLocked;
        end
    end
endmodule
`default_nettype wire

// >>> verilog/btd_ctrl_end.sv
// Purpose: memory controller side: makes K/Kn, issues bursts, collects reads
// Assumes: user side on core_clk; one request per K period
// Notes: data changes half a K period away from the edge that samples it
`default_nettype none
module btd_ctrl_end #(
    parameter int AW = btd_pkg::ADDR_W_DEF,
    parameter int HALF_DIV = btd_pkg::HALF_DIV_DEF,
    parameter int TURN_IDLE = btd_pkg::TURN_IDLE_DEF
) (
    input wire logic core_clk,
    input wire logic arst_n,
    btd_link_if.ctrl link,
    input wire logic pllEnable,
    input wire logic reqValid,
    input wire logic reqRead,
    input wire logic [AW-1:0] reqAddr,
    input wire logic [btd_pkg::WORD_W-1:0] reqData0,
    input wire logic [btd_pkg::WORD_W-1:0] reqData1,
    input wire logic [btd_pkg::LANES-1:0] reqMaskN0,
    input wire logic [btd_pkg::LANES-1:0] reqMaskN1,
    output logic rdReady,
    output logic wrReady,
    output logic rspValid,
    output logic [btd_pkg::WORD_W-1:0] rspData0,
    output logic [btd_pkg::WORD_W-1:0] rspData1
);
    localparam int WW = btd_pkg::WORD_W;
    localparam int NL = btd_pkg::LANES;
    localparam int DW = $clog2(HALF_DIV);
    localparam int TW = $clog2(TURN_IDLE + 1);
    localparam int KW = $clog2(btd_pkg::LOCK_CYC + 1);

    generate
        if (HALF_DIV < 4 || TURN_IDLE < 2) begin : gBadParam
            $error("btd_ctrl_end: unsupported parameters");
        end
    endgenerate

    logic [WW+2:0] syncOut;
    logic eS, enS, rvS;
    logic [WW-1:0] dqS;
    btd_sync #(.W(WW + 3)) uSync (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .din({link.echoClk, link.echoClkN, link.readValid, link.dq}),
        .dout(syncOut)
    );
    assign {eS, enS, rvS, dqS} = syncOut;

    logic [DW-1:0] divCnt, next_divCnt;
    logic [TW-1:0] turnCnt, next_turnCnt;
    logic [KW-1:0] lockCnt, next_lockCnt;
    logic wrPend, next_wrPend, wrPend1, next_wrPend1;
    logic [WW-1:0] wd0, wd1, w1Hold, next_wd0, next_wd1, next_w1Hold;
    logic [NL-1:0] wm0, wm1, m1Hold, next_wm0, next_wm1, next_m1Hold;
    logic ePrev, enPrev, exp1, next_exp1;
    logic next_kClk, next_loadN, next_readSel, next_dqHostOeN;
    logic [AW-1:0] next_addr;
    logic [NL-1:0] next_maskN;
    logic [WW-1:0] next_dqHost, next_rsp0, next_rsp1;
    logic next_rdReady, next_wrReady, next_rspValid;
    logic toggle, lockDone, take;

    assign toggle = divCnt == DW'(HALF_DIV - 1);
    assign lockDone = lockCnt == KW'(btd_pkg::LOCK_CYC) || !pllEnable;
    assign take = reqValid && (reqRead ? rdReady : wrReady);

    always_comb begin
        next_divCnt = toggle ? '0 : divCnt + 1'b1;
        next_kClk = toggle ? !link.kClk : link.kClk;
        next_lockCnt = (!pllEnable || lockDone) ? lockCnt : lockCnt + 1'b1;
        if (!pllEnable) begin
            next_lockCnt = '0;
        end
        next_rdReady = divCnt == DW'(HALF_DIV - 2) && link.kClk && lockDone;
        next_wrReady = next_rdReady && turnCnt == '0;
        next_turnCnt = turnCnt;
        next_loadN = link.loadN;
        next_readSel = link.readSel;
        next_addr = link.addr;
        next_maskN = link.byteMaskN;
        next_dqHost = link.dqHost;
        next_dqHostOeN = link.dqHostOeN;
        next_wrPend = wrPend;
        next_wrPend1 = wrPend1;
        {next_wd0, next_wd1, next_wm0, next_wm1} = {wd0, wd1, wm0, wm1};
        next_w1Hold = w1Hold;
        next_m1Hold = m1Hold;
        if (toggle && link.kClk) begin
            // K about to fall: set up the next K rise
            next_loadN = !take;
            if (take) begin
                next_readSel = reqRead;
                next_addr = reqAddr;
            end
            if (take && reqRead) begin
                next_turnCnt = TW'(TURN_IDLE);
            end else if (turnCnt != '0) begin
                next_turnCnt = turnCnt - 1'b1;
            end
            if (wrPend) begin
                next_dqHost = wd0;
                next_maskN = wm0;
                next_dqHostOeN = 1'b0;
                next_w1Hold = wd1;
                next_m1Hold = wm1;
            end else begin
                next_dqHostOeN = 1'b1;
                next_maskN = '1;
            end
            next_wrPend1 = wrPend;
            next_wrPend = take && !reqRead;
            if (take) begin
                {next_wd0, next_wd1, next_wm0, next_wm1} = {reqData0, reqData1, reqMaskN0, reqMaskN1};
            end
        end
        if (toggle && !link.kClk && wrPend1) begin
            next_dqHost = w1Hold;
            next_maskN = m1Hold;
        end
        next_exp1 = exp1;
        next_rspValid = 1'b0;
        next_rsp0 = rspData0;
        next_rsp1 = rspData1;
        if (eS && !ePrev && rvS) begin
            next_rsp0 = dqS;
            next_exp1 = 1'b1;
        end
        if (enS && !enPrev && exp1) begin
            next_rsp1 = dqS;
            next_rspValid = 1'b1;
            next_exp1 = 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            divCnt <= '0;
            turnCnt <= '0;
            lockCnt <= '0;
            {wrPend, wrPend1, exp1, ePrev, enPrev} <= '0;
            {wd0, wd1, w1Hold, wm0, wm1, m1Hold} <= '0;
            link.kClk <= 1'b0;
            link.kClkN <= 1'b1;
            link.loadN <= 1'b1;
            link.readSel <= 1'b0;
            link.addr <= '0;
            link.byteMaskN <= '1;
            link.dqHost <= '0;
            link.dqHostOeN <= 1'b1;
            link.loopBypassN <= 1'b0;
            rdReady <= 1'b0;
            wrReady <= 1'b0;
            rspValid <= 1'b0;
            rspData0 <= '0;
            rspData1 <= '0;
        end else begin
            divCnt <= next_divCnt;
            turnCnt <= next_turnCnt;
            lockCnt <= next_lockCnt;
            {wrPend, wrPend1, exp1, ePrev, enPrev} <= {next_wrPend, next_wrPend1, next_exp1, eS, enS};
            {wd0, wd1, w1Hold} <= {next_wd0, next_wd1, next_w1Hold};
            {wm0, wm1, m1Hold} <= {next_wm0, next_wm1, next_m1Hold};
            link.kClk <= next_kClk;
            link.kClkN <= !next_kClk;
            link.loadN <= next_loadN;
            link.readSel <= next_readSel;
            link.addr <= next_addr;
            link.byteMaskN <= next_maskN;
            link.dqHost <= next_dqHost;
            link.dqHostOeN <= next_dqHostOeN;
            link.loopBypassN <= pllEnable;
            rdReady <= next_rdReady;
            wrReady <= next_wrReady;
            rspValid <= next_rspValid;
            rspData0 <= next_rsp0;
            rspData1 <= next_rsp1;
        end
    end
endmodule
`default_nettype wire

// >>> verification/btd_link_properties.sv
// Purpose: pin timing checks between controller end and SRAM end
// Assumes: K period of eight core cycles
// Notes: windows allow for the two-flop sampling of K in the SRAM end
`default_nettype none
module btd_link_properties #(
    parameter int AW = 4
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic kClk,
    input wire logic kClkN,
    input wire logic loadN,
    input wire logic readSel,
    input wire logic loopBypassN,
    input wire logic [btd_pkg::LANES-1:0] byteMaskN,
    input wire logic [AW-1:0] addr,
    input wire logic [btd_pkg::WORD_W-1:0] dqHost,
    input wire logic dqHostOeN,
    input wire logic [btd_pkg::WORD_W-1:0] dqDev,
    input wire logic dqDevOeN,
    input wire logic [btd_pkg::WORD_W-1:0] dq,
    input wire logic echoClk,
    input wire logic echoClkN,
    input wire logic readValid
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    logic kPrev;
    logic kRise;
    logic [5:0] sinceRd;
    logic [5:0] next_sinceRd;
    assign kRise = kClk && !kPrev;
    // cycles since the last read was loaded, saturating
    always_comb begin
        next_sinceRd = sinceRd;
        if (kRise && !loadN && readSel) begin
            next_sinceRd = 6'h00;
        end else if (sinceRd != 6'h3F) begin
            next_sinceRd = sinceRd + 6'h01;
        end
    end
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            kPrev <= 1'h0;
            sinceRd <= 6'h3F;
        end else begin
            kPrev <= kClk;
            sinceRd <= next_sinceRd;
        end
    end
    sequence s_rd_load;
        kRise && !loadN && readSel;
    endsequence
    sequence s_wr_load;
        kRise && !loadN && !readSel;
    endsequence
    property p_pll_latency;
        s_rd_load ##0 (loopBypassN && dqDevOeN && sinceRd >= 6'h19) |->
            ##1 dqDevOeN[*8] ##1 dqDevOeN[*6] ##[1:10] !dqDevOeN;
    endproperty
    a_pll_latency: assert property (p_pll_latency) else $error("pll read latency wrong");
    property p_leg_latency;
        s_rd_load ##0 (!loopBypassN && dqDevOeN) |-> ##[6:16] !dqDevOeN;
    endproperty
    a_leg_latency: assert property (p_leg_latency) else $error("legacy latency wrong");
    property p_load_hold;
        $fell(loadN) |-> (!loadN)[*8];
    endproperty
    a_load_hold: assert property (p_load_hold) else $error("load not held one K");
    property p_wr_data;
        s_wr_load |-> ##[1:12] !dqHostOeN;
    endproperty
    a_wr_data: assert property (p_wr_data) else $error("write data not driven");
    property p_turn;
        s_wr_load |-> sinceRd >= 6'h17;
    endproperty
    a_turn: assert property (p_turn) else $error("read to write too close");
    property p_echo;
        kRise |-> ##[1:4] $rose(echoClk);
    endproperty
    a_echo: assert property (p_echo) else $error("echo clock lost");
    property p_echo_n;
        $rose(kClkN) |-> ##[1:4] $rose(echoClkN);
    endproperty
    a_echo_n: assert property (p_echo_n) else $error("inverse echo clock lost");
    property p_vld_lead;
        $rose(readValid) |-> ##[2:6] !dqDevOeN;
    endproperty
    a_vld_lead: assert property (p_vld_lead) else $error("valid not leading data");
    property p_vld_cover;
        $fell(dqDevOeN) |-> readValid;
    endproperty
    a_vld_cover: assert property (p_vld_cover) else $error("data without valid");
    property p_float;
        $fell(readValid) |-> ##[0:8] dqDevOeN;
    endproperty
    a_float: assert property (p_float) else $error("bus not released");
endmodule
`default_nettype wire

// >>> verification/burst_two_ddr_sram_port_tb.sv
// Purpose: self-checking bench for both link ends joined together
// Assumes: 50 ns core clock, default K divider
// Notes: one run with the loop on, one in legacy mode
`default_nettype none
module burst_two_ddr_sram_port_tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int AW = 4;
    localparam int CAL_CYC = btd_pkg::IMP_CAL_K * 2 * btd_pkg::HALF_DIV_DEF;
    logic core_clk;
    logic arst_n;
    logic pllEnable;
    logic reqValid = 1'h0;
    logic reqRead = 1'h0;
    logic [AW-1:0] reqAddr = '0;
    logic [17:0] reqData0 = '0;
    logic [17:0] reqData1 = '0;
    logic [1:0] reqMaskN0 = 2'h3;
    logic [1:0] reqMaskN1 = 2'h3;
    logic rdReady, wrReady, rspValid, pllLocked, impCalPulse;
    logic [17:0] rspData0, rspData1;
    logic [17:0] mem0 [16];
    logic [17:0] mem1 [16];
    logic [35:0] expQ [$];
    int mismatches = 0;
    int compares = 0;
    int cycles = 0;
    int calCnt = 0;
    int calSeen = 0;
    integer seed = 66972;
    btd_link_if #(.AW(AW)) u_btd_link_if ();
    btd_sram_end #(.AW(AW)) u_btd_sram_end (.core_clk(core_clk), .arst_n(arst_n),
        .link(u_btd_link_if.sram), .pllLocked(pllLocked), .impCalPulse(impCalPulse));
    btd_ctrl_end #(.AW(AW)) u_btd_ctrl_end (.core_clk(core_clk), .arst_n(arst_n),
        .link(u_btd_link_if.ctrl), .pllEnable(pllEnable), .reqValid(reqValid),
        .reqRead(reqRead), .reqAddr(reqAddr), .reqData0(reqData0), .reqData1(reqData1),
        .reqMaskN0(reqMaskN0), .reqMaskN1(reqMaskN1), .rdReady(rdReady), .wrReady(wrReady),
        .rspValid(rspValid), .rspData0(rspData0), .rspData1(rspData1));
    btd_link_properties #(.AW(AW)) u_btd_link_properties (.core_clk(core_clk),
        .arst_n(arst_n), .kClk(u_btd_link_if.kClk), .kClkN(u_btd_link_if.kClkN),
        .loadN(u_btd_link_if.loadN), .readSel(u_btd_link_if.readSel),
        .loopBypassN(u_btd_link_if.loopBypassN), .byteMaskN(u_btd_link_if.byteMaskN),
        .addr(u_btd_link_if.addr), .dqHost(u_btd_link_if.dqHost),
        .dqHostOeN(u_btd_link_if.dqHostOeN), .dqDev(u_btd_link_if.dqDev),
        .dqDevOeN(u_btd_link_if.dqDevOeN), .dq(u_btd_link_if.dq),
        .echoClk(u_btd_link_if.echoClk), .echoClkN(u_btd_link_if.echoClkN),
        .readValid(u_btd_link_if.readValid));
    task automatic final_report();
        $display("mismatches %0d compares %0d", mismatches, compares);
        if (mismatches == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // low mask bit stores its lane
    function automatic logic [17:0] merge(input logic [17:0] old, input logic [17:0] d,
        input logic [1:0] mk);
        merge = old;
        for (int l = 0; l < btd_pkg::LANES; l++) begin
            if (!mk[l]) merge[l*btd_pkg::LANE_W +: btd_pkg::LANE_W] =
                d[l*btd_pkg::LANE_W +: btd_pkg::LANE_W];
        end
    endfunction
    // request stays up until the edge that follows a ready pulse
    task automatic issue(input logic rd, input logic [AW-1:0] a, input logic [17:0] d0,
        input logic [17:0] d1, input logic [1:0] m0, input logic [1:0] m1);
        int n;
        n = 0;
        reqRead = rd;
        reqAddr = a;
        reqData0 = d0;
        reqData1 = d1;
        reqMaskN0 = m0;
        reqMaskN1 = m1;
        reqValid = 1'h1;
        while ((rd ? rdReady : wrReady) !== 1'h1 && n < 2000) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        chk(36'(n < 2000), 36'h1);
        @(posedge core_clk);
        #1;
        if (rd) begin
            expQ.push_back({mem1[a], mem0[a]});
        end else begin
            mem0[a] = merge(mem0[a], d0, m0);
            mem1[a] = merge(mem1[a], d1, m1);
        end
    endtask
    task automatic run_phase(input logic pll);
        int op;
        arst_n = 1'h0;
        pllEnable = pll;
        expQ.delete();
        repeat (4) @(posedge core_clk);
        #1;
        arst_n = 1'h1;
        if (pll) begin
            repeat (200) @(posedge core_clk);
            chk(36'(pllLocked), 36'h0);
        end
        for (int i = 0; i < 16; i++) begin
            issue(1'h0, 4'(i), 18'($random(seed)), 18'($random(seed)), 2'h0, 2'h0);
        end
        chk(36'(pllLocked), 36'(pll));
        for (int i = 0; i < 16; i++) begin
            issue(1'h0, 4'h5, 18'($random(seed)), 18'($random(seed)), i[1:0], i[3:2]);
            issue(1'h1, 4'h5, 18'h0, 18'h0, 2'h3, 2'h3);
        end
        for (int i = 0; i < 40; i++) begin
            op = $random(seed);
            issue(op[0], op[7:4], 18'($random(seed)), 18'($random(seed)), op[9:8],
                op[11:10]);
            if (op[1]) issue(1'h1, op[7:4], 18'h0, 18'h0, 2'h3, 2'h3);
        end
        reqValid = 1'h0;
        op = 0;
        while ((expQ.size() != 0 || (pll && calSeen < 2)) && op < 20000) begin
            @(posedge core_clk);
            #1;
            op++;
        end
        chk(36'(expQ.size()), 36'h0);
        if (pll) chk(36'(calSeen >= 2), 36'h1);
    endtask
    initial begin
        core_clk = 1'h0;
        forever #25 core_clk = ~core_clk;
    end
    always @(negedge core_clk) begin
        cycles++;
        if (cycles > 40000) begin
            mismatches++;
            $display("ERROR %0t: run did not finish", $time);
            final_report();
        end else if (!arst_n) begin
            calSeen = 0;
            calCnt = 0;
        end else begin
            calCnt++;
            if (impCalPulse === 1'h1) begin
                if (calSeen > 0) chk(36'(calCnt), 36'(CAL_CYC));
                calSeen++;
                calCnt = 0;
            end
            if (rspValid === 1'h1) begin
                if (expQ.size() == 0) chk(36'h1, 36'h0);
                else chk({rspData1, rspData0}, expQ.pop_front());
            end
        end
    end
    initial begin
        run_phase(1'h1);
        run_phase(1'h0);
        final_report();
    end
endmodule
`default_nettype wire
